// ---- timer_channel.v ----
`include "timer_channel_defs.vh"

// Contract
// - Mode A picks capture or compare
// - Edge/level 00 releases pin to GPIO
// - Capture edge: rising, falling, or both
// - Compare match toggles, clears or sets pin
// - Mode B gives edge-aligned PWM, edge A sets polarity
// - Center-aligned select gives center-aligned PWM
// - Channel value bytes reset to zero
// - Capture reads latch both bytes coherently
// - Control write unlatches read buffer always
// - Value writes ignored in capture mode
// - Debug halt freezes read-latch state on value reads
// - Halt reads return live register bytes
// - Compare/PWM writes buffered until both bytes
// - No clock: transfer on second byte
// - Clocked compare: transfer at counter change
// - Clocked PWM: transfer at modulo step
// - Control write resets write-buffer sequence
// - Halt writes go direct, sequence frozen
// - Halt writes keep partial sequence intact
// - Flag cleared by read-then-write-zero
// - Clock select 00 means counter stopped
// - Center-aligned select overrides channel modes
// - Active edge captures counter, sets flag
module timer_channel (
    // Clock and reset
    input wire ref_clk,
    input wire arst_n,
    // Avalon-MM slave
    input wire [3:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output wire waitrequest,
    // Shared counter side
    input wire center_aligned_select,
    input wire counter_clock_select_hi,
    input wire counter_clock_select_lo,
    input wire [15:0] counter_value,
    input wire [15:0] modulo_value,
    input wire debug_halt,
    // Channel pin
    input wire chan_pin_in,
    output reg chan_pin_out,
    output wire chan_pin_oe,
    // Status
    output wire chan_event_flag,
    output wire [15:0] chan_value
);

    // ==========================================
    // Mode codes
    localparam MODE_CAP = 2'h0;
    localparam MODE_OC = 2'h1;
    localparam MODE_EDGE_ALIGNED_PWM = 2'h2;
    localparam MODE_CENTER_ALIGNED_PWM = 2'h3;

    // Decode channel mode from select bits
    function [1:0] chan_mode;
        input cas;
        input msb;
        input msa;
        begin
            if (cas)
                chan_mode = MODE_CENTER_ALIGNED_PWM;
            else if (msb)
                chan_mode = MODE_EDGE_ALIGNED_PWM;
            else if (msa)
                chan_mode = MODE_OC;
            else
                chan_mode = MODE_CAP;
        end
    endfunction

    // ==========================================
    // Reset release
    reg rst_meta; // First release stage
    reg rst_sync; // Released reset, active low

    // Two-stage release of the async reset
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ==========================================
    // State
    reg ack; // Bus answer phase
    reg event_flag; // Channel event flag
    reg int_enable; // Interrupt enable bit, stored only
    reg mode_b; // chan_mode_select_b
    reg mode_a; // chan_mode_select_a
    reg edge_b; // chan_edge_level_b
    reg edge_a; // chan_edge_level_a
    reg clr_armed; // Flag read while set
    reg [15:0] value; // Channel value register
    reg [15:0] rd_buf; // Read coherency buffer
    reg rd_latched; // Read buffer holds a pair
    reg rd_first_hi; // High byte was read first
    reg [15:0] wr_buf; // Write coherency buffer
    reg wr_hi_done; // High byte buffered
    reg wr_lo_done; // Low byte buffered
    reg wr_pending; // Pair waits for transfer
    reg pin_prev; // Pin level one cycle ago
    reg [15:0] cnt_prev; // Counter one cycle ago

    // ==========================================
    // Decodes
    wire [1:0] mode = chan_mode(center_aligned_select, mode_b, mode_a);
    wire [1:0] edge_sel = {edge_b, edge_a};
    wire pin_used = (edge_sel != 2'h0);
    wire is_cap = (mode == MODE_CAP);
    wire is_pwm = (mode == MODE_EDGE_ALIGNED_PWM) || (mode == MODE_CENTER_ALIGNED_PWM);
    wire clk_running = ({counter_clock_select_hi, counter_clock_select_lo}
        != `CLK_SEL_NONE);

    // Bus phases: requests are taken in the answer cycle
    wire req = read | write;
    assign waitrequest = req & ~ack;
    wire rd_first = read & ~ack; // Read data formed here
    wire wr_fire = write & ack; // Write takes effect here
    wire rd_fire = read & ack; // Read completes here
    wire sel_sc = (address == `OFS_STATUS_CONTROL);
    wire sel_vh = (address == `OFS_VALUE_HIGH);
    wire sel_vl = (address == `OFS_VALUE_LOW);
    wire sc_write = wr_fire & sel_sc;

    // Counter motion
    wire cnt_changed = (counter_value != cnt_prev);
    wire cnt_up = (counter_value > cnt_prev);
    wire match = cnt_changed && (counter_value == value);

    // Capture edge select
    wire rise = chan_pin_in & ~pin_prev;
    wire fall = ~chan_pin_in & pin_prev;
    reg cap_edge;
    always @*
    begin
        // Choose active edge
        case (edge_sel)
            2'h1: cap_edge = rise;
            2'h2: cap_edge = fall;
            2'h3: cap_edge = rise | fall;
            default: cap_edge = 1'b0;
        endcase
    end
    wire capture = is_cap & pin_used & cap_edge;

    // Compare event, not for 0% or 100% PWM duty
    wire pwm_edge_duty = is_pwm && ((value == 16'h0000) || (value > modulo_value
        && modulo_value != 16'h0000));
    wire cmp_event = ~is_cap & match & ~pwm_edge_duty;
    wire chan_event = capture | cmp_event;

    // Buffered value transfer moment
    wire [15:0] mod_minus = modulo_value - 16'h0001;
    wire pwm_step = (modulo_value == 16'h0000) ?
        (cnt_prev == `CNT_ALMOST_FULL && counter_value == `CNT_FULL) :
        (cnt_prev == mod_minus && counter_value == modulo_value);
    wire transfer_now = wr_pending &&
        (is_pwm ? pwm_step : cnt_changed);

    // ==========================================
    // Bus answer and read data
    always @(posedge ref_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            ack <= 1'b0;
            readdata <= 32'h00000000;
        end
        else
        begin
            // Answer one cycle after a request appears
            ack <= req & ~ack;
            if (rd_first)
            begin
                // Narrow registers sit in the low byte
                readdata <= 32'h00000000;
                if (sel_sc)
                    readdata[7:0] <= {event_flag, int_enable, mode_b, mode_a,
                        edge_b, edge_a, 2'h0};
                else if (sel_vh)
                begin
                    if (is_cap && rd_latched && !debug_halt)
                        readdata[7:0] <= rd_buf[15:8];
                    else
                        readdata[7:0] <= value[15:8];
                end
                else if (sel_vl)
                begin
                    if (is_cap && rd_latched && !debug_halt)
                        readdata[7:0] <= rd_buf[7:0];
                    else
                        readdata[7:0] <= value[7:0];
                end
            end
        end
    end

    // ==========================================
    // Status/control register and event flag
    always @(posedge ref_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            event_flag <= 1'b0;
            int_enable <= 1'b0;
            mode_b <= 1'b0;
            mode_a <= 1'b0;
            edge_b <= 1'b0;
            edge_a <= 1'b0;
            clr_armed <= 1'b0;
        end
        else
        begin
            if (sc_write)
            begin
                // Control bits take the written byte
                int_enable <= writedata[`BIT_INT_ENABLE];
                mode_b <= writedata[`BIT_MODE_B];
                mode_a <= writedata[`BIT_MODE_A];
                edge_b <= writedata[`BIT_EDGE_B];
                edge_a <= writedata[`BIT_EDGE_A];
            end
            // New event wins over a clear
            if (chan_event)
            begin
                event_flag <= 1'b1;
                clr_armed <= 1'b0;
            end
            else if (sc_write && clr_armed && !writedata[`BIT_EVENT_FLAG])
            begin
                event_flag <= 1'b0;
                clr_armed <= 1'b0;
            end
            else if (rd_fire && sel_sc && event_flag)
                clr_armed <= 1'b1;
        end
    end

    // ==========================================
    // Read coherency
    always @(posedge ref_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            rd_buf <= `RST_CHANNEL_VALUE;
            rd_latched <= 1'b0;
            rd_first_hi <= 1'b0;
        end
        else if (sc_write)
            rd_latched <= 1'b0;
        else if (rd_fire && is_cap && !debug_halt && (sel_vh || sel_vl))
        begin
            if (!rd_latched)
            begin
                // First half read: hold both bytes
                rd_buf <= value;
                rd_latched <= 1'b1;
                rd_first_hi <= sel_vh;
            end
            else if (rd_first_hi != sel_vh)
                rd_latched <= 1'b0; // Other half read
        end
    end

    // ==========================================
    // Channel value and write coherency
    wire val_write = wr_fire && (sel_vh || sel_vl) && !is_cap;
    wire hi_next = wr_hi_done | sel_vh;
    wire lo_next = wr_lo_done | sel_vl;
    wire [15:0] buf_next = sel_vh ? {writedata[7:0], wr_buf[7:0]} :
        {wr_buf[15:8], writedata[7:0]};

    always @(posedge ref_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            value <= `RST_CHANNEL_VALUE;
            wr_buf <= `RST_CHANNEL_VALUE;
            wr_hi_done <= 1'b0;
            wr_lo_done <= 1'b0;
            wr_pending <= 1'b0;
        end
        else
        begin
            // Pending pair moves in at its moment
            if (transfer_now && !debug_halt)
            begin
                value <= wr_buf;
                wr_pending <= 1'b0;
            end
            if (capture)
                value <= counter_value;
            if (sc_write)
            begin
                // Sequence starts over
                wr_hi_done <= 1'b0;
                wr_lo_done <= 1'b0;
                wr_pending <= 1'b0;
            end
            else if (val_write && debug_halt)
            begin
                // Direct write, buffer untouched
                if (sel_vh)
                    value[15:8] <= writedata[7:0];
                else
                    value[7:0] <= writedata[7:0];
            end
            else if (val_write)
            begin
                wr_buf <= buf_next;
                if (hi_next && lo_next)
                begin
                    wr_hi_done <= 1'b0;
                    wr_lo_done <= 1'b0;
                    if (!clk_running)
                    begin
                        value <= buf_next;
                        wr_pending <= 1'b0;
                    end
                    else
                        wr_pending <= 1'b1;
                end
                else
                begin
                    wr_hi_done <= hi_next;
                    wr_lo_done <= lo_next;
                end
            end
        end
    end

    // ==========================================
    // Pin and counter history
    always @(posedge ref_clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            pin_prev <= 1'b0;
            cnt_prev <= 16'h0000;
        end
        else
        begin
            pin_prev <= chan_pin_in;
            cnt_prev <= counter_value;
        end
    end

    // ==========================================
    // Output pin drive
    wire low_true = edge_a; // X1 selects low-true pulses
    wire edge_aligned_pwm_start = cnt_changed && (counter_value == 16'h0000);

    always @(posedge ref_clk or negedge rst_sync)
    begin
        if (!rst_sync)
            chan_pin_out <= 1'b0;
        else if (!pin_used)
            chan_pin_out <= 1'b0;
        else
        begin
            case (mode)
                MODE_OC:
                begin
                    // Compare action on the pin
                    if (match)
                    begin
                        if (edge_sel == 2'h1)
                            chan_pin_out <= ~chan_pin_out;
                        else
                            chan_pin_out <= edge_b & edge_a;
                    end
                end
                MODE_EDGE_ALIGNED_PWM:
                begin
                    // Period start then compare end
                    if (match)
                        chan_pin_out <= low_true;
                    else if (edge_aligned_pwm_start)
                        chan_pin_out <= ~low_true;
                end
                MODE_CENTER_ALIGNED_PWM:
                begin
                    // Up-compare ends, down-compare starts
                    if (match && cnt_up)
                        chan_pin_out <= low_true;
                    else if (match)
                        chan_pin_out <= ~low_true;
                end
                default:
                    chan_pin_out <= 1'b0; // Capture drives nothing
            endcase
        end
    end

    // ==========================================
    // Outputs
    assign chan_pin_oe = pin_used & ~is_cap;
    assign chan_event_flag = event_flag;
    assign chan_value = value;

endmodule

// ---- timer_channel_defs.vh ----
`ifndef TIMER_CHANNEL_DEFS_VH
`define TIMER_CHANNEL_DEFS_VH

// ==========================================
// Register byte addresses on the bus
`define OFS_STATUS_CONTROL 4'h0
`define OFS_VALUE_HIGH 4'h4
`define OFS_VALUE_LOW 4'h8

// ==========================================
// Status/control field positions
`define BIT_EVENT_FLAG 7
`define BIT_INT_ENABLE 6
`define BIT_MODE_B 5
`define BIT_MODE_A 4
`define BIT_EDGE_B 3
`define BIT_EDGE_A 2

// ==========================================
// Reset values
`define RST_STATUS_CONTROL 8'h00
`define RST_CHANNEL_VALUE 16'h0000

// ==========================================
// Counter constants
`define CNT_ALMOST_FULL 16'hFFFE
`define CNT_FULL 16'hFFFF
`define CLK_SEL_NONE 2'h0

`endif

// ---- timer_channel_checker.sv ----
module timer_channel_checker (
    // Clock and reset
    input wire ref_clk,
    input wire arst_n,
    // Register bus
    input wire [3:0] address,
    input wire write,
    input wire [31:0] writedata,
    input wire waitrequest,
    // Counter side
    input wire center_aligned_select,
    input wire [15:0] counter_value,
    input wire debug_halt,
    // Channel pin and status
    input wire chan_pin_in,
    input wire chan_pin_out,
    input wire chan_pin_oe,
    input wire chan_event_flag,
    input wire [15:0] chan_value
);
    // ==========================================
    // Shadow of the mode and edge bits
    logic [5:2] ctl; // Mode and edge/level copy
    wire wr_ctl = write && !waitrequest && address == 4'h0; // Control write taken
    wire cap = !center_aligned_select && ctl[5:4] == 2'b00; // Capture mode
    wire cmp = !center_aligned_select && ctl[5:4] == 2'b01; // Compare mode
    // Follow accepted control writes
    always @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            ctl <= 4'h0;
        else if (wr_ctl)
            ctl <= writedata[5:2];
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // ==========================================
    // Properties
    a_gpio_release: assert property (ctl[3:2] == 2'b00 |-> !chan_pin_oe)
        else $error("pin driven while released");
    a_capture_no_drive: assert property (cap |-> !chan_pin_oe)
        else $error("pin driven in capture mode");
    a_compare_drives: assert property (cmp && ctl[3:2] != 2'b00 |-> chan_pin_oe)
        else $error("pin not driven in compare mode");
    a_value_reset: assert property ($rose(arst_n) |-> chan_value == 16'h0000)
        else $error("value not cleared by reset");
    a_capture_rise: assert property (cap && ctl[3:2] == 2'b01 && $rose(chan_pin_in) && !wr_ctl
        |=> chan_event_flag && chan_value == $past(counter_value))
        else $error("rising edge not captured");
    a_capture_fall: assert property (cap && ctl[3:2] == 2'b10 && $fell(chan_pin_in) && !wr_ctl
        |=> chan_event_flag && chan_value == $past(counter_value))
        else $error("falling edge not captured");
    a_capture_hold: assert property (cap && $stable(chan_pin_in) && !wr_ctl
        |=> $stable(chan_value))
        else $error("value changed without edge");
    a_compare_set: assert property (cmp && ctl[3:2] == 2'b11 && !debug_halt && !wr_ctl
        && $changed(counter_value) && counter_value == chan_value |-> ##[1:2] chan_pin_out)
        else $error("pin not set on match");
endmodule

// ---- pin_partner.sv ----
module pin_partner (
    // Clock
    input wire ref_clk,
    // Requested level and pin wires
    input wire level,
    input wire pin_oe,
    input wire pin_out,
    output logic pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drive = 1'b0; // External driver level
    // Driver moves only on clock edges, held for many cycles
    always @(posedge ref_clk)
        drive <= level;
    // Wire level from both parties
    assign pin_in = pin_oe ? pin_out : drive;
endmodule

// ---- timer_channel_tb.sv ----
module timer_channel_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Signals
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic clk_sel_lo = 1'b0; // Counter clock running
    logic center_aligned_select = 1'b0; // Module-wide center-aligned PWM
    logic [15:0] counter_value = 16'h0;
    logic [15:0] modulo_value = 16'h0;
    logic debug_halt = 1'b0;
    logic pin_level = 1'b0; // External pin request
    logic chan_pin_in, chan_pin_out, chan_pin_oe, chan_event_flag;
    logic [15:0] chan_value;
    logic [7:0] q; // Last byte read
    int n_errors = 0;
    int n_checks = 0;
    always #10 ref_clk = ~ref_clk;
    timer_channel dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .center_aligned_select(center_aligned_select), .counter_clock_select_hi(1'b0),
        .counter_clock_select_lo(clk_sel_lo), .counter_value(counter_value),
        .modulo_value(modulo_value), .debug_halt(debug_halt), .chan_pin_in(chan_pin_in),
        .chan_pin_out(chan_pin_out), .chan_pin_oe(chan_pin_oe),
        .chan_event_flag(chan_event_flag), .chan_value(chan_value));
    pin_partner pin_u (.ref_clk(ref_clk), .level(pin_level), .pin_oe(chan_pin_oe),
        .pin_out(chan_pin_out), .pin_in(chan_pin_in));
    // ==========================================
    // Shared tasks
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One bus access, held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= {24'h0, d};
        read <= !w;
        write <= w;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0)
        begin
            n_errors++;
            stop_test();
        end
        // Read data taken at the accepting edge, then the request drops
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task rd(input string nm, input logic [3:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(nm, {8'h00, q}, {8'h00, exp});
    endtask
    // Observed output: 0 value, 1 pin drive, 2 flag
    function automatic logic [15:0] obs(input int s);
        return s == 0 ? chan_value : {15'h0, s == 1 ? chan_pin_out : chan_event_flag};
    endfunction
    // Bounded wait at falling edges, then back to a rising edge
    task automatic look(input string nm, input int s, input logic [15:0] exp, input int lim);
        int n;
        n = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while (obs(s) !== exp && n < lim);
        chk(nm, obs(s), exp);
        if (obs(s) !== exp && lim > 1)
            stop_test();
        @(posedge ref_clk);
    endtask
    // ==========================================
    // Scenarios
    task t_reset;
        rd("status", 4'h0, 8'h00);
        rd("value high", 4'h4, 8'h00);
        rd("value low", 4'h8, 8'h00);
        rd("unmapped", 4'hC, 8'h00);
        $display("reset test done");
    endtask
    task t_compare;
        bus(1'b1, 4'h0, 8'h1C);
        bus(1'b1, 4'h4, 8'h12);
        look("half pair", 0, 16'h0000, 1);
        bus(1'b1, 4'h8, 8'h34);
        look("stopped transfer", 0, 16'h1234, 1);
        clk_sel_lo <= 1'b1;
        bus(1'b1, 4'h8, 8'h78);
        bus(1'b1, 4'h4, 8'h56);
        look("pending pair", 0, 16'h1234, 1);
        counter_value <= 16'h0001;
        look("clocked transfer", 0, 16'h5678, 4);
        counter_value <= 16'h5678;
        look("set on match", 1, 16'h0001, 4);
        $display("compare test done");
    endtask
    task t_capture;
        // Flag from the compare match is cleared first
        rd("flag before clear", 4'h0, 8'h9C);
        bus(1'b1, 4'h0, 8'h04);
        look("flag clear on write", 2, 16'h0000, 1);
        counter_value <= 16'hABCD;
        pin_level <= 1'b1;
        look("rise capture", 0, 16'hABCD, 6);
        look("event flag", 2, 16'h0001, 1);
        rd("latch high", 4'h4, 8'hAB);
        counter_value <= 16'h2222;
        pin_level <= 1'b0;
        repeat (3) @(posedge ref_clk);
        look("no fall capture", 0, 16'hABCD, 1);
        pin_level <= 1'b1;
        look("second capture", 0, 16'h2222, 6);
        debug_halt <= 1'b1;
        rd("halt live low", 4'h8, 8'h22);
        debug_halt <= 1'b0;
        rd("buffered low", 4'h8, 8'hCD);
        bus(1'b1, 4'h4, 8'h77);
        look("write ignored", 0, 16'h2222, 1);
        rd("flag armed", 4'h0, 8'h84);
        bus(1'b1, 4'h0, 8'h08);
        look("flag cleared", 2, 16'h0000, 1);
        counter_value <= 16'h3333;
        pin_level <= 1'b0;
        look("fall capture", 0, 16'h3333, 6);
        $display("capture test done");
    endtask
    task t_pwm_halt;
        bus(1'b1, 4'h0, 8'h28);
        modulo_value <= 16'h0010;
        counter_value <= 16'h0005;
        bus(1'b1, 4'h4, 8'h00);
        bus(1'b1, 4'h8, 8'h08);
        counter_value <= 16'h000F;
        rd("before modulo step", 4'h4, 8'h33);
        counter_value <= 16'h0010;
        look("modulo step", 0, 16'h0008, 4);
        bus(1'b1, 4'h8, 8'h55);
        debug_halt <= 1'b1;
        bus(1'b1, 4'h4, 8'h3C);
        look("direct halt write", 0, 16'h3C08, 1);
        rd("halt live read", 4'h4, 8'h3C);
        debug_halt <= 1'b0;
        bus(1'b1, 4'h4, 8'h44);
        counter_value <= 16'h000F;
        look("pair still pending", 0, 16'h3C08, 1);
        counter_value <= 16'h0010;
        look("buffered pair", 0, 16'h4455, 4);
        $display("pwm and halt test done");
    endtask
    task t_center;
        // Counter stopped so the pair lands on the second byte
        clk_sel_lo <= 1'b0;
        center_aligned_select <= 1'b1;
        bus(1'b1, 4'h0, 8'h08);
        bus(1'b1, 4'h4, 8'h00);
        bus(1'b1, 4'h8, 8'h04);
        look("center value", 0, 16'h0004, 1);
        counter_value <= 16'h0005;
        @(posedge ref_clk);
        counter_value <= 16'h0004;
        look("down compare", 1, 16'h0001, 4);
        counter_value <= 16'h0003;
        @(posedge ref_clk);
        counter_value <= 16'h0004;
        look("up compare", 1, 16'h0000, 4);
        $display("center-aligned test done");
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_compare();
        t_capture();
        t_pwm_halt();
        t_center();
        stop_test();
    end
endmodule

bind timer_channel timer_channel_checker chk_u (.ref_clk(ref_clk), .arst_n(arst_n),
    .address(address), .write(write), .writedata(writedata), .waitrequest(waitrequest),
    .center_aligned_select(center_aligned_select), .counter_value(counter_value),
    .debug_halt(debug_halt), .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out),
    .chan_pin_oe(chan_pin_oe), .chan_event_flag(chan_event_flag), .chan_value(chan_value));
